// file: hw/rfpll_defs.vh
`ifndef RFPLL_DEFS_VH
`define RFPLL_DEFS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define RFPLL_ADDR_W 3
`define RFPLL_OFF_ZHI 3'h0
`define RFPLL_OFF_ZLO 3'h1
`define RFPLL_OFF_OHI 3'h2
`define RFPLL_OFF_OLO 3'h3
`define RFPLL_OFF_CTL 3'h4
// ----------------------------------------
// field positions
// ----------------------------------------
`define RFPLL_FRAC_LO_MSB 7
`define RFPLL_FRAC_LO_LSB 3
`define RFPLL_INV_BIT 2
`define RFPLL_BAND_BIT 2
`define RFPLL_KEY_BIT 1
`define RFPLL_REF_BIT 0
`define RFPLL_RST_BIT 0
`define RFPLL_PAGE_BIT 1
`define RFPLL_CODE_MSB 1
`define RFPLL_CODE_LSB 0
// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define RFPLL_BYTE_RST 8'h00
`define RFPLL_LOW_RST 5'h00
`define RFPLL_CODE_MAN 2'h0
`define RFPLL_CODE_BIP 2'h1
`define RFPLL_CODE_NRZ 2'h2
`define RFPLL_CODE_MCU 2'h3
`define RFPLL_INT_BASE 5'h0c
`define RFPLL_INT_BAND 5'h04
// ----------------------------------------
// timing
// ----------------------------------------
`define RFPLL_CLK_KHZ 40000
`define RFPLL_REF_KHZ 500
`define RFPLL_REF_HALF (`RFPLL_CLK_KHZ / (2 * `RFPLL_REF_KHZ))
`endif

// file: hw/rfpll_refdiv.v
`timescale 1ns/1ps
`include "rfpll_defs.vh"
// ----------------------------------------
// reference clock divider
// ----------------------------------------
module rfpll_refdiv #(
   parameter HALF = `RFPLL_REF_HALF
) (
   input wire clk_i,
   input wire srst_i,
   input wire en_i,
   output reg ref_o
);
   reg [7:0] cnt_r;
   // stopped divider holds low so the timer sees no stray edge
   always @(posedge clk_i) begin
      if (srst_i || !en_i) begin
         cnt_r <= 8'h00;
         ref_o <= 1'b0;
      end else if (cnt_r == HALF - 1) begin
         cnt_r <= 8'h00;
         ref_o <= ~ref_o;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
endmodule // rfpll_refdiv

// file: hw/rfpll_regs.v
`timescale 1ns/1ps
`include "rfpll_defs.vh"
// Notes on behaviour
// - zero fraction = first register as bits 12:5, second reg 7:3 as 4:0.
// - ratio = 12 + 4*band + fraction/8192, given as integer and fraction.
// - zero fraction clears on radio block reset.
// - one fraction = third register as 12:5, fourth reg 7:3 as 4:0.
// - one fraction clears on radio block reset.
// - the four registers decode only while buffer page select is zero.
// - second reg bit 2 inverts NRZ and direct data; cleared on reset.
// - encoding field picks Manchester, bi-phase, NRZ or direct data.
// - encoding field clears to Manchester on reset.
// - fourth reg bit 2 picks 315 (0) or 434 (1) MHz band; clears.
// - fourth reg bit 1 picks OOK (0) or FSK (1); clears on reset.
// - fourth reg bit 0 gates the 500 kHz timer reference clock.
// - buffer page select lives in control two and picks the page.
module rfpll_regs (
   input wire CLK_I,
   input wire SRST_I,
   input wire [`RFPLL_ADDR_W-1:0] ADDR_I,
   input wire [7:0] WDATA_I,
   input wire WR_I,
   input wire RD_I,
   output reg [7:0] RDATA_O,
   input wire SYMBOL_I,
   input wire MCU_DATA_I,
   output reg [4:0] DIV_INT_O,
   output reg [12:0] DIV_FRAC_O,
   output reg [1:0] ENCODING_O,
   output reg DATA_INVERT_O,
   output reg DIRECT_DATA_O,
   output reg CARRIER_BAND_SELECT_O,
   output reg KEYING_SELECT_O,
   output wire TIMER_REFERENCE_CLOCK_O,
   output reg BUFFER_PAGE_SELECT_O
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] zhi_r;
   reg [4:0] zlo_r;
   reg data_invert_r;
   reg [1:0] code_r;
   reg [7:0] ohi_r;
   reg [4:0] olo_r;
   reg band_r;
   reg keying_r;
   reg ref_en_r;
   reg page_r;
   reg radio_rst_r;
   reg sym_s1_r;
   reg sym_r;
   reg mcu_s1_r;
   reg mcu_r;
   wire page_ok;
   wire [12:0] zero_frac;
   wire [12:0] one_frac;
   wire sel_zero;

   // block reset from the system reset or the software pulse
   wire radio_rst = SRST_I | radio_rst_r;
   assign page_ok = ~page_r;
   assign zero_frac = {zhi_r, zlo_r};
   assign one_frac = {ohi_r, olo_r};

   function hit;
      input [`RFPLL_ADDR_W-1:0] a;
      input [`RFPLL_ADDR_W-1:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         sym_s1_r <= 1'b0;
         sym_r <= 1'b0;
         mcu_s1_r <= 1'b0;
         mcu_r <= 1'b0;
      end else begin
         sym_s1_r <= SYMBOL_I;
         sym_r <= sym_s1_r;
         mcu_s1_r <= MCU_DATA_I;
         mcu_r <= mcu_s1_r;
      end
   end

   // ----------------------------------------
   // control register (page select, reset pulse)
   // ----------------------------------------
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         page_r <= 1'b0;
         radio_rst_r <= 1'b0;
      end else begin
         // one-cycle pulse; never stored, so it always reads zero
         radio_rst_r <= WR_I && hit(ADDR_I, `RFPLL_OFF_CTL) &&
            WDATA_I[`RFPLL_RST_BIT];
         if (WR_I && hit(ADDR_I, `RFPLL_OFF_CTL)) begin
            page_r <= WDATA_I[`RFPLL_PAGE_BIT];
         end
      end
   end

   // ----------------------------------------
   // pll control registers
   // ----------------------------------------
   always @(posedge CLK_I) begin
      if (radio_rst) begin
         zhi_r <= `RFPLL_BYTE_RST;
         zlo_r <= `RFPLL_LOW_RST;
         data_invert_r <= 1'b0;
         code_r <= `RFPLL_CODE_MAN;
         ohi_r <= `RFPLL_BYTE_RST;
         olo_r <= `RFPLL_LOW_RST;
         band_r <= 1'b0;
         keying_r <= 1'b0;
      end else if (WR_I && page_ok) begin
         if (hit(ADDR_I, `RFPLL_OFF_ZHI)) begin
            zhi_r <= WDATA_I;
         end
         if (hit(ADDR_I, `RFPLL_OFF_ZLO)) begin
            zlo_r <= WDATA_I[`RFPLL_FRAC_LO_MSB:`RFPLL_FRAC_LO_LSB];
            data_invert_r <= WDATA_I[`RFPLL_INV_BIT];
            code_r <= WDATA_I[`RFPLL_CODE_MSB:`RFPLL_CODE_LSB];
         end
         if (hit(ADDR_I, `RFPLL_OFF_OHI)) begin
            ohi_r <= WDATA_I;
         end
         if (hit(ADDR_I, `RFPLL_OFF_OLO)) begin
            olo_r <= WDATA_I[`RFPLL_FRAC_LO_MSB:`RFPLL_FRAC_LO_LSB];
            band_r <= WDATA_I[`RFPLL_BAND_BIT];
            keying_r <= WDATA_I[`RFPLL_KEY_BIT];
         end
      end
   end

   // reference enable survives block reset; only system reset clears it
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         ref_en_r <= 1'b0;
      end else if (WR_I && page_ok && hit(ADDR_I, `RFPLL_OFF_OLO)) begin
         ref_en_r <= WDATA_I[`RFPLL_REF_BIT];
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         RDATA_O <= 8'h00;
      end else if (RD_I) begin
         case (ADDR_I)
            `RFPLL_OFF_ZHI: RDATA_O <= page_ok ? zhi_r : 8'h00;
            `RFPLL_OFF_ZLO: RDATA_O <= page_ok ?
               {zlo_r, data_invert_r, code_r} : 8'h00;
            `RFPLL_OFF_OHI: RDATA_O <= page_ok ? ohi_r : 8'h00;
            `RFPLL_OFF_OLO: RDATA_O <= page_ok ?
               {olo_r, band_r, keying_r, ref_en_r} : 8'h00;
            `RFPLL_OFF_CTL: RDATA_O <= {6'h00, page_r, 1'b0};
            default: RDATA_O <= 8'h00;
         endcase
      end else begin
         RDATA_O <= 8'h00;
      end
   end

   // ----------------------------------------
   // divider word and data path
   // ----------------------------------------
   // OOK keys the carrier on with the one fraction only
   assign sel_zero = keying_r && !sym_r;

   always @(posedge CLK_I) begin
      if (SRST_I) begin
         DIV_INT_O <= `RFPLL_INT_BASE;
         DIV_FRAC_O <= 13'h0000;
         ENCODING_O <= `RFPLL_CODE_MAN;
         DATA_INVERT_O <= 1'b0;
         DIRECT_DATA_O <= 1'b0;
         CARRIER_BAND_SELECT_O <= 1'b0;
         KEYING_SELECT_O <= 1'b0;
         BUFFER_PAGE_SELECT_O <= 1'b0;
      end else begin
         DIV_INT_O <= band_r ? `RFPLL_INT_BASE + `RFPLL_INT_BAND :
            `RFPLL_INT_BASE;
         DIV_FRAC_O <= sel_zero ? zero_frac : one_frac;
         ENCODING_O <= code_r;
         DATA_INVERT_O <= data_invert_r;
         // direct mode: pin data to the output, polarity applied
         DIRECT_DATA_O <= (code_r == `RFPLL_CODE_MCU) ?
            (mcu_r ^ data_invert_r) : 1'b0;
         CARRIER_BAND_SELECT_O <= band_r;
         KEYING_SELECT_O <= keying_r;
         BUFFER_PAGE_SELECT_O <= page_r;
      end
   end

   rfpll_refdiv #(
      .HALF(`RFPLL_REF_HALF)
   ) u_refdiv (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .en_i(ref_en_r),
      .ref_o(TIMER_REFERENCE_CLOCK_O)
   );
endmodule // rfpll_regs

// file: testbench/rf_pll_control_regs_test.sv
`timescale 1ns/1ps
// ---------------------
// bench
// ---------------------
module rf_pll_control_regs_test;
   reg clk = 0, srst = 1, wr = 0, rd = 0, sym = 0, mcu = 0;
   reg [2:0] addr = 0;
   reg [7:0] wdata = 0;
   wire [7:0] rdata;
   wire [4:0] dint;
   wire [12:0] frac;
   wire [1:0] enc;
   wire inv, dd, band, key, rc, page;
   wire [17:0] ratio;
   integer err_total = 0, total_checks = 0, i, n;
   logic [15:0] rows [5] = '{16'h00a5, 16'h01d9, 16'h023c, 16'h0377, 16'h0400};
   rfpll_regs dut_u (.CLK_I(clk), .SRST_I(srst), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .SYMBOL_I(sym), .MCU_DATA_I(mcu), .DIV_INT_O(dint), .DIV_FRAC_O(frac),
      .ENCODING_O(enc), .DATA_INVERT_O(inv), .DIRECT_DATA_O(dd),
      .CARRIER_BAND_SELECT_O(band), .KEYING_SELECT_O(key),
      .TIMER_REFERENCE_CLOCK_O(rc), .BUFFER_PAGE_SELECT_O(page));
   rfpll_radio_model far_u (.clk_i(clk), .int_i(dint), .frac_i(frac),
      .ratio_o(ratio));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task chk(input [17:0] seen, input [17:0] exp, input [63:0] nm);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task wr_reg(input [2:0] a, input [7:0] d);
      @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clk) wr <= 0;
   endtask
   task rd_chk(input [2:0] a, input [7:0] e);
      @(posedge clk) {addr, rd} <= {a, 1'b1};
      @(posedge clk) rd <= 0;
      #1 chk(rdata, e, "rdata");
   endtask
   task settle;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      begin : scen
         repeat (6) @(posedge clk);
         srst <= 0;
         for (i = 0; i < 5; i = i + 1) begin
            wr_reg(rows[i][10:8], rows[i][7:0]);
            rd_chk(rows[i][10:8], rows[i][7:0]);
         end
         settle;
         chk({enc, inv}, 3'h2, "encinv");
         chk({band, key}, 2'h3, "bandkey");
         chk(frac, 13'h14bb, "frac0");
         chk(ratio, 18'h214bb, "ratio");
         @(posedge clk) sym <= 1;
         settle;
         chk(frac, 13'h078e, "frac1");
         wr_reg(3, 8'h71);
         sym <= 0;
         settle;
         chk(ratio, 18'h1878e, "ook");
         $display("test divider done");
         @(posedge clk) mcu <= 1;
         for (i = 0; i < 4; i = i + 1) begin
            wr_reg(1, 8'hd8 | i[7:0]);
            settle;
            chk({enc, dd}, {i[1:0], i == 3}, "code");
         end
         wr_reg(1, 8'hdf);
         settle;
         chk({inv, dd}, 2'h2, "invert");
         wr_reg(4, 8'h02);
         settle;
         chk(page, 1, "page");
         rd_chk(0, 0);
         wr_reg(0, 8'hff);
         rd_chk(4, 8'h02);
         rd_chk(5, 0);
         wr_reg(4, 0);
         rd_chk(0, 8'ha5);
         $display("test page done");
         // start from a low phase so the count sees a whole high phase
         for (n = 0; n < 99 && rc !== 1'b0; n = n + 1) begin
            @(posedge clk) #1;
         end
         for (n = 0; n < 99 && rc !== 1'b1; n = n + 1) begin
            @(posedge clk) #1;
         end
         if (n > 98) begin
            err_total = err_total + 1;
            disable scen;
         end
         for (n = 0; n < 99 && rc === 1'b1; n = n + 1) begin
            @(posedge clk) #1;
         end
         chk(n, 40, "refhalf");
         if (n > 98) begin
            err_total = err_total + 1;
            disable scen;
         end
         wr_reg(4, 8'h01);
         settle;
         for (i = 0; i < 4; i = i + 1) begin
            rd_chk(i[2:0], i == 3);
         end
         wr_reg(3, 0);
         settle;
         // a full reference period must pass with the output held low
         n = 0;
         repeat (90) begin
            @(posedge clk) #1;
            if (rc !== 1'b0) n = n + 1;
         end
         chk(n, 0, "refoff");
         wr_reg(1, 8'hff);
         srst <= 1;
         @(posedge clk) srst <= 0;
         settle;
         chk({enc, inv, dint}, 8'h0c, "reset");
         $display("test resets done");
      end
      end_of_test;
   end
endmodule // rf_pll_control_regs_test

// file: testbench/rfpll_radio_model.sv
`timescale 1ns/1ps
// ---------------------
// divider consumer
// ---------------------
module rfpll_radio_model (
   input wire clk_i,
   input wire [4:0] int_i,
   input wire [12:0] frac_i,
   output reg [17:0] ratio_o
);
   // one number in 1/8192 steps; the loop itself sees two controls
   always @(posedge clk_i) begin
      ratio_o <= {int_i, frac_i};
   end
endmodule // rfpll_radio_model

// file: testbench/rfpll_regs_sva.sv
`timescale 1ns/1ps
// ---------------------
// register bank checker
// ---------------------
module rfpll_chk (
   input wire CLK_I,
   input wire SRST_I,
   input wire [2:0] ADDR_I,
   input wire [7:0] WDATA_I,
   input wire WR_I,
   input wire RD_I,
   input wire [7:0] RDATA_O,
   input wire SYMBOL_I,
   input wire MCU_DATA_I,
   input wire [4:0] DIV_INT_O,
   input wire [12:0] DIV_FRAC_O,
   input wire [1:0] ENCODING_O,
   input wire DATA_INVERT_O,
   input wire DIRECT_DATA_O,
   input wire CARRIER_BAND_SELECT_O,
   input wire KEYING_SELECT_O,
   input wire TIMER_REFERENCE_CLOCK_O,
   input wire BUFFER_PAGE_SELECT_O
);
   wire rc = TIMER_REFERENCE_CLOCK_O;
   wire pg = BUFFER_PAGE_SELECT_O;
   wire bd = CARRIER_BAND_SELECT_O;
   reg q_r;
   reg [5:0] run_r;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   // run length of the reference level, reset so it never stays unknown
   always @(posedge CLK_I) begin
      q_r <= rc;
      run_r <= (SRST_I || rc != q_r) ? 6'h00 : run_r + 6'h01;
   end
   rd_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
      else $error("read data not zero when idle");
   band_int_a: assert property ($stable(bd)
      |-> DIV_INT_O == (bd ? 5'h10 : 5'h0c))
      else $error("integer divider wrong for band");
   direct_off_a: assert property ($stable(ENCODING_O) && ENCODING_O != 2'h3
      |-> !DIRECT_DATA_O)
      else $error("direct data active outside direct mode");
   ref_half_a: assert property (rc && q_r && run_r == 6'd38 |=> !rc)
      else $error("reference high phase too long");
   page_hide_a: assert property (RD_I && ADDR_I < 3'h4 && pg
      |=> !pg || RDATA_O == 8'h00) else $error("page one read leaked");
   unmapped_a: assert property (RD_I && ADDR_I > 3'h4
      |=> RDATA_O == 8'h00) else $error("unmapped read not zero");
   rst_bit_a: assert property (RD_I && ADDR_I == 3'h4 |=> !RDATA_O[0])
      else $error("reset bit reads one");
   rst_vals_a: assert property ($fell(SRST_I)
      |-> DIV_FRAC_O == 13'h0 && ENCODING_O == 2'h0 && !DATA_INVERT_O
      && !KEYING_SELECT_O && !bd)
      else $error("outputs not cleared by reset");
   cover property (RD_I && pg);
   cover property ($rose(rc));
   cover property (KEYING_SELECT_O && SYMBOL_I);
endmodule // rfpll_chk
bind rfpll_regs rfpll_chk chk_u (.*);
